// ==== logic/dfp_top.sv ====
// Debug flash programming port: two-wire link, register set and pin sharing.
//
// Overview of operation
// RL1: Flash data register takes commands, addresses, data from host and returns data bytes.
// RL2: Codes 0x06 and 0x07 start block read and block write; both decoded.
// RL3: Code 0x08 starts single page erase; code 0x03 erases whole device.
// RL4: Host talks on the link only while the device is halted.
// RL5: While halted, peripherals and user program execution are stalled.
// RL6: Halted port takes reset pin as link clock and a port pin as data.
// RL7: Data shares a general-purpose pin only on the small package variant.
// RL8: User logic feeding the shared pin holds it steady while halted.
// RL9: The reset pin doubling as link clock is only an input, never driven.
// RL10: Address select picks identifier, revision, control or flash data register.
// RL11: Link uses one host-driven clock and one bidirectional data line.
// RL12: Part identifier is eight bits, read-only, fixed, and ignores writes.
`include "dfp_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module dfp_top #(
  parameter logic [7:0] PART_CODE = 8'h5a, // Arbitrary value.
  parameter logic [7:0] REV_CODE = 8'h01   // Arbitrary value.
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic halt_i,
  input wire logic small_pkg_i,
  output logic stall_o,
  output logic core_reset_o,
  input wire logic debug_clock_pin_i,
  input wire logic shared_pin_i,
  output logic shared_pin_o,
  output logic shared_pin_oe_o,
  input wire logic dedicated_pin_i,
  output logic dedicated_pin_o,
  output logic dedicated_pin_oe_o,
  input wire logic user_data_i,
  input wire logic user_data_oe_i,
  output logic user_data_o,
  output logic [7:0] flash_ctl_o,
  output logic flash_cmd_valid_o,
  output dfp_pkg::dfp_flash_cmd_t flash_cmd_o,
  output logic flash_byte_valid_o,
  output logic [7:0] flash_byte_o,
  output logic flash_rd_o,
  input wire logic flash_rdata_valid_i,
  input wire logic [7:0] flash_rdata_i,
  input wire logic flash_done_i
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // Decodes a byte written while no flash sequence is open.
  function automatic dfp_pkg::dfp_flash_cmd_t decode_cmd(input logic [7:0] code);
    dfp_pkg::dfp_flash_cmd_t cmd;
    cmd = dfp_pkg::DFP_FC_NONE;
    unique case (code)
      `DFP_CMD_BLOCK_READ: cmd = dfp_pkg::DFP_FC_BLOCK_READ; // RL2
      `DFP_CMD_BLOCK_WRITE: cmd = dfp_pkg::DFP_FC_BLOCK_WRITE; // RL2
      `DFP_CMD_PAGE_ERASE: cmd = dfp_pkg::DFP_FC_PAGE_ERASE; // RL3
      `DFP_CMD_DEVICE_ERASE: cmd = dfp_pkg::DFP_FC_DEVICE_ERASE; // RL3
      default: cmd = dfp_pkg::DFP_FC_NONE;
    endcase
    return cmd;
  endfunction

  // Returns the data register picked by the address select value.
  function automatic logic [7:0] read_reg(input logic [7:0] sel, input logic [7:0] ctl,
                                          input logic [7:0] dat);
    logic [7:0] val;
    val = 8'h00;
    unique case (sel)
      `DFP_ADDR_PART_ID: val = PART_CODE; // RL12
      `DFP_ADDR_REV_ID: val = REV_CODE;
      `DFP_ADDR_FP_CTL: val = ctl;
      `DFP_ADDR_FP_DATA: val = dat;
      default: val = 8'h00;
    endcase
    return val;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and strap capture
  // ----------------------------------------------------------------

  logic [2:0] pin_sync;
  logic clk_s;
  logic clk_d;
  logic clk_rise;
  logic data_s;
  logic small_pkg;
  logic strap_done;

  dfp_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .async_i({dedicated_pin_i, shared_pin_i, debug_clock_pin_i}),
    .sync_o(pin_sync)
  );

  assign clk_s = pin_sync[0];
  assign data_s = small_pkg ? pin_sync[1] : pin_sync[2]; // RL7

  // Catches the package strap once, on the first edge after reset release.
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      strap_done <= 1'b0;
      small_pkg <= 1'b0;
    end
    else if (!strap_done)
    begin
      strap_done <= 1'b1;
      small_pkg <= small_pkg_i;
    end
  end

  // Delays the synchronised link clock to find its rising edges.
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      clk_d <= 1'b0;
    else
      clk_d <= clk_s;
  end

  assign clk_rise = clk_s & ~clk_d & halt_i; // RL4 RL11

  // ----------------------------------------------------------------
  // Halt and pin sharing
  // ----------------------------------------------------------------

  // Stalls the core while halted; the reset pin resets the core only when running.
  assign stall_o = halt_i; // RL5
  assign core_reset_o = ~clk_s & ~halt_i; // RL6 RL9

  // ----------------------------------------------------------------
  // Link frame engine
  // ----------------------------------------------------------------

  dfp_pkg::dfp_link_state_t state;
  logic [2:0] bit_cnt;
  logic [1:0] ins;
  logic [7:0] shift;
  logic wr_done;
  logic rd_done;
  logic drive;
  logic [7:0] addr_sel;
  logic [7:0] fp_ctl;
  logic [7:0] fp_data;
  logic flash_open;

  // Frame: start bit 1, two instruction bits, then eight data bits either way.
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i || !halt_i)
    begin
      state <= dfp_pkg::DFP_IDLE;
      bit_cnt <= 3'h0;
      ins <= 2'h0;
      shift <= 8'h00;
    end
    else if (clk_rise)
    begin
      unique case (state)
        dfp_pkg::DFP_IDLE:
        begin
          bit_cnt <= 3'h0;
          if (data_s)
            state <= dfp_pkg::DFP_INS;
        end
        dfp_pkg::DFP_INS:
        begin
          ins <= {data_s, ins[1]};
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == `DFP_INS_LAST)
          begin
            bit_cnt <= 3'h0;
            if ({data_s, ins[1]} == `DFP_INS_ADDR_RD)
            begin
              // First bit 0 with second bit 1 is address read.
              state <= dfp_pkg::DFP_RDATA;
              shift <= addr_sel;
            end
            else if ({data_s, ins[1]} == `DFP_INS_DATA_RD)
            begin
              state <= dfp_pkg::DFP_RDATA;
              shift <= read_reg(addr_sel, fp_ctl, fp_data); // RL10
            end
            else
              state <= dfp_pkg::DFP_WDATA;
          end
        end
        dfp_pkg::DFP_WDATA:
        begin
          shift <= {data_s, shift[7:1]};
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == `DFP_BYTE_LAST)
            state <= dfp_pkg::DFP_IDLE;
        end
        dfp_pkg::DFP_RDATA:
        begin
          shift <= {1'b0, shift[7:1]};
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == `DFP_BYTE_LAST)
            state <= dfp_pkg::DFP_IDLE;
        end
      endcase
    end
  end

  // Frame completion strobes.
  assign wr_done = clk_rise && state == dfp_pkg::DFP_WDATA && bit_cnt == `DFP_BYTE_LAST;
  assign rd_done = clk_rise && state == dfp_pkg::DFP_RDATA && bit_cnt == `DFP_BYTE_LAST
                   && ins == `DFP_INS_DATA_RD && addr_sel == `DFP_ADDR_FP_DATA;

  // Data line drive: device owns the line only during the read data field.
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      drive <= 1'b0;
    else
      drive <= halt_i && state == dfp_pkg::DFP_RDATA
               && !(clk_rise && bit_cnt == `DFP_BYTE_LAST);
  end

  // Steers the data line to the shared or dedicated pin.
  assign shared_pin_o = (halt_i && small_pkg) ? shift[0] : user_data_i; // RL6 RL7
  assign shared_pin_oe_o = (halt_i && small_pkg) ? drive : user_data_oe_i; // RL8
  assign dedicated_pin_o = shift[0];
  assign dedicated_pin_oe_o = drive & ~small_pkg; // RL7
  assign user_data_o = pin_sync[1];

  // ----------------------------------------------------------------
  // Register set
  // ----------------------------------------------------------------

  // Address select and control register writes; identifier writes are dropped.
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      addr_sel <= `DFP_ADDR_RESET;
      fp_ctl <= `DFP_CTL_RESET;
    end
    else if (wr_done)
    begin
      if (ins == `DFP_INS_ADDR_WR)
        addr_sel <= shift[7:1] == 7'h00 ? {data_s, 7'h00} : {data_s, shift[7:1]};
      else if (addr_sel == `DFP_ADDR_FP_CTL)
        fp_ctl <= {data_s, shift[7:1]}; // RL10 RL12
    end
  end

  assign flash_ctl_o = fp_ctl;

  // Flash data register: host write wins over returned flash data.
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      fp_data <= `DFP_DATA_RESET;
    else if (wr_done && ins == `DFP_INS_DATA_WR && addr_sel == `DFP_ADDR_FP_DATA)
      fp_data <= {data_s, shift[7:1]}; // RL1
    else if (flash_rdata_valid_i)
      fp_data <= flash_rdata_i; // RL1
  end

  // ----------------------------------------------------------------
  // Flash sequence control
  // ----------------------------------------------------------------

  logic fp_write;
  assign fp_write = wr_done && ins == `DFP_INS_DATA_WR && addr_sel == `DFP_ADDR_FP_DATA;

  // First byte of a sequence is a command; later bytes are addresses or data.
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      flash_open <= 1'b0;
      flash_cmd_valid_o <= 1'b0;
      flash_cmd_o <= dfp_pkg::DFP_FC_NONE;
      flash_byte_valid_o <= 1'b0;
      flash_byte_o <= 8'h00;
      flash_rd_o <= 1'b0;
    end
    else
    begin
      flash_cmd_valid_o <= 1'b0;
      flash_byte_valid_o <= 1'b0;
      flash_rd_o <= rd_done; // RL1
      if (fp_write && !flash_open)
      begin
        flash_cmd_o <= decode_cmd({data_s, shift[7:1]}); // RL2 RL3
        if (decode_cmd({data_s, shift[7:1]}) != dfp_pkg::DFP_FC_NONE)
        begin
          flash_cmd_valid_o <= 1'b1;
          flash_open <= 1'b1;
        end
      end
      else if (fp_write)
      begin
        flash_byte_valid_o <= 1'b1; // RL1
        flash_byte_o <= {data_s, shift[7:1]};
      end
      else if (flash_done_i)
        flash_open <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ==== logic/dfp_defs.svh ====
// Constants for the debug flash programming port: addresses, codes, frame counts.
`ifndef DFP_DEFS_SVH
`define DFP_DEFS_SVH

// Address select values for the data register set.
`define DFP_ADDR_PART_ID 8'h00
`define DFP_ADDR_REV_ID 8'h01
`define DFP_ADDR_FP_CTL 8'h02
`define DFP_ADDR_FP_DATA 8'had

// Flash command codes carried by the flash programming data register.
`define DFP_CMD_BLOCK_READ 8'h06
`define DFP_CMD_BLOCK_WRITE 8'h07
`define DFP_CMD_PAGE_ERASE 8'h08
`define DFP_CMD_DEVICE_ERASE 8'h03

// Link instruction codes, two bits, sent least significant bit first.
`define DFP_INS_DATA_RD 2'h0
`define DFP_INS_DATA_WR 2'h1
`define DFP_INS_ADDR_RD 2'h2
`define DFP_INS_ADDR_WR 2'h3

// Frame field lengths, counted as last bit index.
`define DFP_INS_LAST 3'h1
`define DFP_BYTE_LAST 3'h7

// Reset values.
`define DFP_ADDR_RESET 8'h00
`define DFP_CTL_RESET 8'h00
`define DFP_DATA_RESET 8'h00

`endif

// ==== logic/dfp_pkg.sv ====
// Types for the debug flash programming port.
package dfp_pkg;

  // Link frame states.
  typedef enum logic [1:0] {
    DFP_IDLE,
    DFP_INS,
    DFP_WDATA,
    DFP_RDATA
  } dfp_link_state_t;

  // Decoded flash commands.
  typedef enum logic [2:0] {
    DFP_FC_NONE,
    DFP_FC_BLOCK_READ,
    DFP_FC_BLOCK_WRITE,
    DFP_FC_PAGE_ERASE,
    DFP_FC_DEVICE_ERASE
  } dfp_flash_cmd_t;

endpackage

// ==== logic/dfp_sync.sv ====
// Two flip-flop synchroniser for pin inputs.
`timescale 1ns/1ps
`default_nettype none

module dfp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage.
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      meta <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta <= async_i;
      sync_o <= meta;
    end
  end

endmodule

`default_nettype wire

// ==== dv/dfp_top_monitor.sv ====
// Checker of the debug port outputs against the port behaviour.
`timescale 1ns/1ps
`default_nettype none
module dfp_top_monitor (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic halt_i,
  input wire logic stall_o,
  input wire logic core_reset_o,
  input wire logic shared_pin_o,
  input wire logic shared_pin_oe_o,
  input wire logic dedicated_pin_oe_o,
  input wire logic user_data_i,
  input wire logic user_data_oe_i,
  input wire logic flash_cmd_valid_o,
  input wire dfp_pkg::dfp_flash_cmd_t flash_cmd_o,
  input wire logic flash_byte_valid_o,
  input wire logic flash_rd_o
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  property p_stall;
    stall_o == halt_i;
  endproperty
  a_stall: assert property (p_stall)
    else $error("stall does not follow halt");
  property p_pass;
    !halt_i && !$past(halt_i) |-> shared_pin_oe_o == user_data_oe_i && shared_pin_o == user_data_i;
  endproperty
  a_pass: assert property (p_pass)
    else $error("shared pin not handed to user");
  property p_ded;
    !halt_i |-> !dedicated_pin_oe_o;
  endproperty
  a_ded: assert property (p_ded)
    else $error("dedicated pin driven while running");
  property p_one;
    !(shared_pin_oe_o && dedicated_pin_oe_o && halt_i);
  endproperty
  a_one: assert property (p_one)
    else $error("both data pins driven");
  property p_rst;
    halt_i |-> !core_reset_o;
  endproperty
  a_rst: assert property (p_rst)
    else $error("clock pin resets core while halted");
  property p_code;
    flash_cmd_valid_o |-> flash_cmd_o != dfp_pkg::DFP_FC_NONE ##1 !flash_cmd_valid_o;
  endproperty
  a_code: assert property (p_code)
    else $error("bad command strobe");
  property p_excl;
    !(flash_cmd_valid_o && flash_byte_valid_o);
  endproperty
  a_excl: assert property (p_excl)
    else $error("flash strobes overlap");
  property p_rdpulse;
    flash_rd_o |=> !flash_rd_o;
  endproperty
  a_rdpulse: assert property (p_rdpulse)
    else $error("flash read strobe longer than one cycle");
  property p_idle;
    !halt_i && !$past(halt_i) && !$past(halt_i, 2) |-> !(flash_cmd_valid_o || flash_byte_valid_o);
  endproperty
  a_idle: assert property (p_idle)
    else $error("flash traffic while running");
endmodule
bind dfp_top dfp_top_monitor u_dfp_top_monitor (.clk_i, .resetn_i, .halt_i, .stall_o,
  .core_reset_o, .shared_pin_o, .shared_pin_oe_o, .dedicated_pin_oe_o, .user_data_i,
  .user_data_oe_i, .flash_cmd_valid_o, .flash_cmd_o, .flash_byte_valid_o, .flash_rd_o);
`default_nettype wire

// ==== dv/dfp_host_model.sv ====
// Model of the external debug and programming host.
`timescale 1ns/1ps
`default_nettype none
module dfp_host_model (
  input wire logic clk_i,
  input wire logic line_i,
  output logic ck_o,
  output logic d_o
);
  // The link clock stands high between frames.
  initial
  begin
    ck_o = 1'b1;
    d_o = 1'b0;
  end
  // One bit: data set while the clock is low, taken at its rise.
  task automatic send_bit(input logic b);
    ck_o = 1'b0;
    d_o = b;
    repeat (10) @(negedge clk_i);
    ck_o = 1'b1;
    repeat (10) @(negedge clk_i);
  endtask
  // One frame; read frames release the line and toggle it as a stand-in.
  task automatic xfer(input logic [1:0] ins, input logic [7:0] wd, output logic [7:0] rd);
    send_bit(1'b1);
    send_bit(ins[0]);
    send_bit(ins[1]);
    rd = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      if (ins[0])
        send_bit(wd[i]);
      else
      begin
        ck_o = 1'b0;
        d_o = ~d_o;
        repeat (10) @(negedge clk_i);
        ck_o = 1'b1;
        rd[i] = line_i;
        repeat (10) @(negedge clk_i);
      end
    end
  endtask
endmodule
`default_nettype wire

// ==== dv/dfp_top_test.sv ====
// Testbench of the debug flash programming port.
`timescale 1ns/1ps
`default_nettype none
module dfp_top_test;
  localparam logic [7:0] PART = 8'h3c; // Arbitrary value.
  localparam logic [7:0] REV = 8'h4b; // Arbitrary value.
  logic clk_i = 1'b0, resetn_i = 1'b0, halt_i = 1'b0, small_pkg_i = 1'b1;
  logic user_data_i = 1'b1, user_data_oe_i = 1'b0, flash_done_i = 1'b0;
  logic flash_rdata_valid_i = 1'b0;
  logic [7:0] flash_rdata_i = 8'h00, flash_ctl_o, flash_byte_o, rd, seen_byte;
  logic stall_o, core_reset_o, shared_pin_o, shared_pin_oe_o, dedicated_pin_o;
  logic dedicated_pin_oe_o, flash_cmd_valid_o, flash_byte_valid_o, flash_rd_o, ck, hd, line;
  dfp_pkg::dfp_flash_cmd_t flash_cmd_o, seen_cmd;
  int mismatches = 0, checked = 0, n_cmd = 0, n_byte = 0, n_rd = 0, n0;
  assign line = shared_pin_oe_o ? shared_pin_o : (dedicated_pin_oe_o ? dedicated_pin_o : hd);
  dfp_top #(.PART_CODE(PART), .REV_CODE(REV)) u_dfp_top (.clk_i, .resetn_i, .halt_i,
    .small_pkg_i, .stall_o, .core_reset_o, .debug_clock_pin_i(ck), .shared_pin_i(line),
    .shared_pin_o, .shared_pin_oe_o, .dedicated_pin_i(line), .dedicated_pin_o,
    .dedicated_pin_oe_o, .user_data_i, .user_data_oe_i, .user_data_o(), .flash_ctl_o,
    .flash_cmd_valid_o, .flash_cmd_o, .flash_byte_valid_o, .flash_byte_o, .flash_rd_o,
    .flash_rdata_valid_i, .flash_rdata_i, .flash_done_i);
  dfp_host_model u_dfp_host_model (.clk_i, .line_i(line), .ck_o(ck), .d_o(hd));
  // ----
  // Clock, strobe capture and helpers
  // ----
  always #2 clk_i = ~clk_i;
  // Count the flash side strobes at the falling edge, where they have settled.
  always @(negedge clk_i)
  begin
    if (flash_cmd_valid_o) begin n_cmd++; seen_cmd = flash_cmd_o; end
    if (flash_byte_valid_o) begin n_byte++; seen_byte = flash_byte_o; end
    if (flash_rd_o) n_rd++;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xf(input logic [1:0] ins, input logic [7:0] wd);
    u_dfp_host_model.xfer(ins, wd, rd);
    repeat (5) @(negedge clk_i);
  endtask
  task automatic end_sim;
    if (mismatches == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_running;
    user_data_oe_i = 1'b1;
    xf(2'h3, 8'h02);
    chk({5'h0, stall_o, shared_pin_oe_o, shared_pin_o}, 8'h03);
    user_data_oe_i = 1'b0;
    halt_i = 1'b1;
    repeat (4) @(negedge clk_i);
    xf(2'h2, 8'h00);
    chk(rd, 8'h00);
  endtask
  task automatic t_ident;
    xf(2'h3, 8'h00);
    xf(2'h0, 8'h00);
    chk(rd, PART);
    xf(2'h1, 8'h33);
    xf(2'h0, 8'h00);
    chk(rd, PART);
    xf(2'h3, 8'h01);
    xf(2'h0, 8'h00);
    chk(rd, REV);
  endtask
  task automatic t_ctl;
    xf(2'h3, 8'h02);
    xf(2'h1, 8'ha5);
    chk(flash_ctl_o, 8'ha5);
    xf(2'h0, 8'h00);
    chk(rd, 8'ha5);
  endtask
  task automatic t_cmds;
    logic [7:0] codes [4] = '{8'h06, 8'h07, 8'h08, 8'h03};
    dfp_pkg::dfp_flash_cmd_t kinds [4] = '{dfp_pkg::DFP_FC_BLOCK_READ,
      dfp_pkg::DFP_FC_BLOCK_WRITE, dfp_pkg::DFP_FC_PAGE_ERASE, dfp_pkg::DFP_FC_DEVICE_ERASE};
    xf(2'h3, 8'had);
    n0 = n_cmd;
    xf(2'h1, 8'h55);
    chk(8'(n_cmd - n0), 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      n0 = n_cmd;
      xf(2'h1, codes[i]);
      chk(8'(n_cmd - n0), 8'h01);
      chk({5'h0, seen_cmd}, {5'h0, kinds[i]});
      n0 = n_byte;
      xf(2'h1, 8'h12 + 8'(i));
      chk(8'(n_byte - n0), 8'h01);
      chk(seen_byte, 8'h12 + 8'(i));
      flash_done_i = 1'b1;
      @(negedge clk_i);
      flash_done_i = 1'b0;
    end
  endtask
  task automatic t_flash_rd;
    flash_rdata_valid_i = 1'b1;
    flash_rdata_i = 8'h6c;
    @(negedge clk_i);
    flash_rdata_valid_i = 1'b0;
    n0 = n_rd;
    xf(2'h0, 8'h00);
    chk(rd, 8'h6c);
    chk(8'(n_rd - n0), 8'h01);
  endtask
  // Main sequence; the user drive on the shared pin holds steady while halted.
  initial
  begin
    repeat (8) @(negedge clk_i);
    resetn_i = 1'b1;
    repeat (8) @(negedge clk_i);
    t_running();
    t_ident();
    t_ctl();
    t_cmds();
    t_flash_rd();
    end_sim();
  end
  // Watchdog well beyond the expected run length.
  initial
  begin
    #200000;
    mismatches++;
    end_sim();
  end
endmodule
`default_nettype wire
